// file: verif/sec_event_ctrl_tb.sv
// self-checking bench for the frame-protection event and pn update block
// assumes a zero-wait ahb-lite slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
`default_nettype none
module sec_event_ctrl_tb
   import sec_event_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   core_fault_t core_fault = '0;
   egress_pn_t egress_pn = '0;
   drop_event_t drop_event = '0;
   in_octet_t in_octet = '0;
   out_pkt_t out_pkt = '0;
   logic [CTX_W-1:0] ctx_addr;
   logic [63:0] ctx_pn_rdata;
   logic [31:0] ctx_window = 32'h0000_0100;
   logic ctx_wr;
   logic [63:0] ctx_pn_wdata;
   logic [63:0] ctx_lowest_pn;
   logic [CTX_W:0] ctx_sel_sa;
   logic [47:0] sa_octets;
   logic [39:0] sa_out_pkts;
   logic crypto_irq;
   logic drop_irq;
   logic [63:0] ctx_mem [NUM_CTX];
   int wr_seen = 0;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   localparam int cbit [5] = '{BIT_INPUT_ERR, BIT_OUTPUT_ERR, BIT_PROC_ERR, BIT_CTX_ERR,
      BIT_FATAL_ERR};

   sec_event_ctrl sec_event_ctrl_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_fault(core_fault),
      .egress_pn(egress_pn), .drop_event(drop_event), .in_octet(in_octet),
      .out_pkt(out_pkt), .ctx_addr(ctx_addr), .ctx_pn_rdata(ctx_pn_rdata),
      .ctx_window(ctx_window), .ctx_wr(ctx_wr), .ctx_pn_wdata(ctx_pn_wdata),
      .ctx_lowest_pn(ctx_lowest_pn), .ctx_sel_sa(ctx_sel_sa), .sa_octets(sa_octets),
      .sa_out_pkts(sa_out_pkts), .crypto_irq(crypto_irq), .drop_irq(drop_irq));

   // ---------------------------------------------------------------
   // clock, context store stand-in, hang guard
   // ---------------------------------------------------------------
   initial begin
      forever #2.5 hclk = ~hclk;
   end

   // combinational read, as the real store answers within the cycle
   assign ctx_pn_rdata = ctx_mem[ctx_addr];

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (ctx_wr === 1'b1) begin
         ctx_mem[ctx_addr] <= ctx_pn_wdata;
         wr_seen <= wr_seen + 1;
      end
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // entered just after a rising edge; holds each phase until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      k = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wr ? d : 32'h0000_0000;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(name, {32'h0000_0000, q}, {32'h0000_0000, exp});
   endtask

   // irq levels are registered: sample one edge after the causing write
   task automatic irq_chk(input logic crypto_exp, input logic drop_exp);
      @(posedge hclk);
      check("crypto_irq", {63'h0, crypto_irq}, {63'h0, crypto_exp});
      check("drop_irq", {63'h0, drop_irq}, {63'h0, drop_exp});
   endtask

   task automatic upd(input logic [2:0] f, input logic [31:0] hi, input logic [31:0] lo,
                      input logic [31:0] ctrl, input int nw, input logic [63:0] mem_exp,
                      input logic [63:0] low_exp);
      logic [31:0] q;
      int w0;
      int k;
      wr(OFF_PN_TARGET_HIGH, hi);
      wr(OFF_PN_TARGET_LOW, lo);
      wr(OFF_PN_TARGET_FLOW_SELECT, {29'h0, f});
      w0 = wr_seen;
      wr(OFF_PN_UPDATE_CTRL, ctrl);
      q = 32'h0000_0001;
      k = 0;
      while (q[BIT_UPDATE_REQ] !== 1'b0 && k < 20) begin
         bus(1'b0, OFF_PN_UPDATE_CTRL, 32'h0000_0000, q);
         k++;
      end
      check("update_req", {63'h0, q[BIT_UPDATE_REQ]}, 64'h0);
      check("ctx_writes", 64'(wr_seen - w0), 64'(nw));
      check("ctx_pn", ctx_mem[f], mem_exp);
      if (nw != 0) begin
         check("lowest_pn", ctx_lowest_pn, low_exp);
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] exp;
      drop_event_t ev;
      for (int i = 0; i < NUM_CTX; i++) begin
         ctx_mem[i] = 64'h0000_0000_0000_0000;
      end
      ctx_mem[3] = 64'h0000_0000_0000_0800;
      ctx_mem[5] = 64'h0000_0000_FFFF_FFF0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(OFF_CRYPTO_ERROR_STATUS, RST_ZERO, "crypto_status_rst");
      rd_chk(OFF_DROP_STATUS, RST_ZERO, "drop_status_rst");
      rd_chk(OFF_PN_WARNING_THRESHOLD, RST_PN_WARNING_THRESHOLD, "threshold_rst");
      // each crypto cause on its own bit, cleared only by a one
      for (int i = 0; i < 5; i++) begin
         core_fault <= core_fault_t'(5'b1_0000 >> i);
         @(posedge hclk);
         core_fault <= '0;
         exp = 32'h0000_0001 << cbit[i];
         rd_chk(OFF_CRYPTO_ERROR_STATUS, exp, "crypto_status");
         irq_chk(1'b0, 1'b0);
         wr(OFF_CRYPTO_ERROR_ENABLE, exp);
         irq_chk(1'b1, 1'b0);
         wr(OFF_CRYPTO_ERROR_STATUS, CRYPTO_STATUS_MASK ^ exp);
         rd_chk(OFF_CRYPTO_ERROR_STATUS, exp, "crypto_keep");
         wr(OFF_CRYPTO_ERROR_STATUS, exp);
         irq_chk(1'b0, 1'b0);
         wr(OFF_CRYPTO_ERROR_ENABLE, RST_ZERO);
      end
      // threshold: equal stays quiet, one above warns
      wr(OFF_PN_WARNING_THRESHOLD, 32'hF000_0000);
      wr(OFF_CRYPTO_ERROR_ENABLE, 32'h0000_0010);
      for (int i = 0; i < 2; i++) begin
         egress_pn <= '{1'b1, 3'd1, 32'hF000_0000 + 32'(i)};
         @(posedge hclk);
         egress_pn <= '0;
         rd_chk(OFF_CRYPTO_ERROR_STATUS, (i == 1) ? 32'h0000_0010 : RST_ZERO, "pn_warn");
         irq_chk(i == 1, 1'b0);
      end
      wr(OFF_CRYPTO_ERROR_ENABLE, RST_ZERO);
      wr(OFF_CRYPTO_ERROR_STATUS, 32'h0000_0010);
      irq_chk(1'b0, 1'b0);
      rd_chk(OFF_CRYPTO_ERROR_STATUS, RST_ZERO, "pn_warn_clr");
      // all seven drop sources, four ingress and three egress lines in total
      for (int i = 0; i < NUM_DROP; i++) begin
         ev = drop_event_t'(7'h40 >> i);
         drop_event <= ev;
         @(posedge hclk);
         drop_event <= '0;
         rd_chk(OFF_DROP_STATUS, {25'h0, ev}, "drop_status");
         irq_chk(1'b0, 1'b0);
         wr(OFF_DROP_ENABLE, 32'h0000_007F);
         irq_chk(1'b0, 1'b1);
         wr(OFF_DROP_STATUS, {25'h0, ev});
         irq_chk(1'b0, 1'b0);
         wr(OFF_DROP_ENABLE, RST_ZERO);
      end
      // forward pn update: advance, equal, backward, extended, below window
      upd(3'd3, 32'h0, 32'h0000_1000, 32'h1, 1, 64'h0000_0000_0000_1000,
          64'h0000_0000_0000_0F00);
      upd(3'd3, 32'h0, 32'h0000_1000, 32'h1, 0, 64'h0000_0000_0000_1000, 64'h0);
      upd(3'd3, 32'h0, 32'h0000_0800, 32'h1, 0, 64'h0000_0000_0000_1000, 64'h0);
      upd(3'd5, 32'h1, 32'h0000_0005, 32'h3, 1, 64'h0000_0001_0000_0005,
          64'h0000_0000_FFFF_FF05);
      upd(3'd6, 32'h1, 32'h0000_0080, 32'h1, 1, 64'h0000_0000_0000_0080,
          64'h0000_0000_0000_0001);
      // shared per-sa counters, selected through the overrun address
      wr(OFF_IN_OVERRUN_COUNT, 32'h0000_0002);
      rd_chk(OFF_IN_OVERRUN_COUNT, RST_ZERO, "overrun");
      in_octet <= '{1'b1, 3'd2, 1'b1, 16'd100};
      out_pkt <= '{1'b1, 3'd2, 1'b1};
      @(posedge hclk);
      in_octet <= '{1'b1, 3'd2, 1'b0, 16'd50};
      out_pkt <= '{1'b1, 3'd2, 1'b0};
      @(posedge hclk);
      in_octet <= '{1'b1, 3'd4, 1'b0, 16'd7};
      out_pkt <= '{1'b1, 3'd4, 1'b0};
      @(posedge hclk);
      in_octet <= '0;
      out_pkt <= '0;
      repeat (3) @(posedge hclk);
      check("sa_octets", {16'h0, sa_octets}, 64'd150);
      check("sa_out_pkts", {24'h0, sa_out_pkts}, 64'd2);
      check("ctx_sel_sa", {60'h0, ctx_sel_sa}, 64'd2);
      check("hresp", {63'h0, hresp}, 64'h0);
      complete_run();
   end
endmodule
`default_nettype wire

// file: verilog/sec_event_ctrl.sv
// event, statistics and packet-number update logic of the frame-protection engine
// assumes ahb-lite single word transfers; the transform datapath reports events as
// one-cycle pulses and owns the context store reached via ctx_* ports
//
// Overview of operation
// R1: five ingress and four egress interrupt sources
// R2: software reads cause, writes ones to clear
// R3: bit 0 on short malformed packet
// R4: bit 1 output error, bit 14 fatal
// R5: bit 2 on flow type mismatch
// R6: bit 3 on invalid transform record
// R7: bit 4 when egress pn passes threshold
// R8: threshold crossing only warns, processing continues
// R9: software programs threshold and enables interrupt
// R10: software disables, clears, rekeys, re-enables
// R11: classification drop raises its interrupt
// R12: ingress consistency drop raises its interrupt
// R13: other post-processing drops raise interrupt
// R14: mtu drop raises its own interrupt
// R15: ingress overrun count reads as zero
// R16: ingress sa shares one octet counter
// R17: egress sa shares one packet counter
// R18: host writes target, flow, then request
// R19: stored pn below target gets replaced
// R20: pn at or above target unchanged
// R21: lowest pn derived from new pn, window
// R22: request bit self-clears after record write
// R23: sources latch, enable gates onto output
`timescale 1ns/1ps
`default_nettype none
module sec_event_ctrl
   import sec_event_pkg::*;
(
   input wire logic hclk, // bus and processing clock
   input wire logic hresetn, // async reset, low active
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire core_fault_t core_fault, // crypto core fault pulses
   input wire egress_pn_t egress_pn, // egress pn report per packet
   input wire drop_event_t drop_event, // drop pulses
   input wire in_octet_t in_octet, // ingress octets per sa
   input wire out_pkt_t out_pkt, // egress packet per sa
   output logic [CTX_W-1:0] ctx_addr, // context store index
   input wire logic [63:0] ctx_pn_rdata, // stored sequence number
   input wire logic [31:0] ctx_window, // replay window size
   output logic ctx_wr, // context write strobe
   output logic [63:0] ctx_pn_wdata, // new sequence number
   output logic [63:0] ctx_lowest_pn, // derived lowest acceptable pn
   output logic [CTX_W:0] ctx_sel_sa, // statistics read select
   output logic [47:0] sa_octets, // selected ingress sa octets
   output logic [39:0] sa_out_pkts, // selected egress sa packets
   output logic crypto_irq, // crypto core interrupt
   output logic drop_irq // any drop interrupt
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] status;
      logic [31:0] enable;
      logic [31:0] threshold;
      logic [NUM_DROP-1:0] drop_st;
      logic [NUM_DROP-1:0] drop_en;
      logic [31:0] tgt_lo;
      logic [31:0] tgt_hi;
      logic [CTX_W-1:0] tgt_ctx;
      logic req;
      logic xpn;
      upd_state_t upd;
      logic [63:0] wdata;
      logic [63:0] lowest;
      logic wr;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
      logic [CTX_W:0] stat_sel;
   } state_t;

   state_t st_reg, st_next;
   logic [NUM_CTX-1:0][47:0] octets_reg;
   logic [NUM_CTX-1:0][39:0] pkts_reg;

   // ---------------------------------------------------------------
   // per sa statistics
   // ---------------------------------------------------------------
   // one shared counter per sa; auth_only is not used here, so splitting
   // into global totals is left to software
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CTX; gi++) begin : g_sa
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               octets_reg[gi] <= 48'h0000_0000_0000;
               pkts_reg[gi] <= 40'h00_0000_0000;
            end else begin
               if (in_octet.valid && in_octet.ctx == CTX_W'(gi)) begin
                  octets_reg[gi] <= octets_reg[gi] + 48'(in_octet.octets); // R16
               end
               if (out_pkt.valid && out_pkt.ctx == CTX_W'(gi)) begin
                  pkts_reg[gi] <= pkts_reg[gi] + 40'h00_0000_0001; // R17
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [31:0] set_bits;
   logic [NUM_DROP-1:0] drop_set;
   logic [31:0] w1c;
   logic [63:0] target;
   logic [63:0] stored;
   logic take;

   always_comb begin
      st_next = st_reg;
      st_next.wr = 1'b0;
      take = hsel && hready && htrans[1];
      target = st_reg.xpn ? {st_reg.tgt_hi, st_reg.tgt_lo} : {32'h0000_0000, st_reg.tgt_lo};
      stored = st_reg.xpn ? ctx_pn_rdata : {32'h0000_0000, ctx_pn_rdata[31:0]};

      set_bits = 32'h0000_0000;
      set_bits[BIT_INPUT_ERR] = core_fault.input_err; // R3
      set_bits[BIT_OUTPUT_ERR] = core_fault.output_err; // R4
      set_bits[BIT_FATAL_ERR] = core_fault.fatal_err; // R4
      set_bits[BIT_PROC_ERR] = core_fault.proc_err; // R5
      set_bits[BIT_CTX_ERR] = core_fault.ctx_err; // R6
      // warning only: nothing here reaches the datapath
      set_bits[BIT_PN_THRESH] = egress_pn.valid && (egress_pn.pn > st_reg.threshold); // R7 R8

      drop_set = {drop_event.in_class, drop_event.in_consist, drop_event.in_post, // R11 R12
         drop_event.in_mtu, drop_event.out_class, drop_event.out_post, // R13
         drop_event.out_mtu}; // R14

      w1c = 32'h0000_0000;
      if (st_reg.ph_valid && st_reg.ph_write) begin
         unique case (st_reg.ph_addr)
            OFF_CRYPTO_ERROR_STATUS: w1c = hwdata; // R2
            OFF_CRYPTO_ERROR_ENABLE: st_next.enable = hwdata & CRYPTO_STATUS_MASK;
            OFF_PN_WARNING_THRESHOLD: st_next.threshold = hwdata;
            OFF_DROP_STATUS: st_next.drop_st = st_reg.drop_st & ~hwdata[NUM_DROP-1:0];
            OFF_DROP_ENABLE: st_next.drop_en = hwdata[NUM_DROP-1:0];
            OFF_PN_TARGET_LOW: st_next.tgt_lo = hwdata;
            OFF_PN_TARGET_HIGH: st_next.tgt_hi = hwdata;
            OFF_PN_TARGET_FLOW_SELECT: st_next.tgt_ctx = hwdata[CTX_W-1:0];
            OFF_IN_OVERRUN_COUNT: st_next.stat_sel = hwdata[CTX_W:0];
            OFF_PN_UPDATE_CTRL: begin
               // a request while one is running is ignored
               if (st_reg.upd == UPD_IDLE) begin
                  st_next.req = hwdata[BIT_UPDATE_REQ]; // R18
                  st_next.xpn = hwdata[BIT_XPN];
               end
            end
            default: ;
         endcase
      end
      // set wins over clear
      st_next.status = ((st_reg.status & ~w1c) | set_bits) & CRYPTO_STATUS_MASK; // R2 R23
      st_next.drop_st = st_next.drop_st | drop_set; // R23

      unique case (st_reg.upd)
         UPD_IDLE: begin
            if (st_reg.req) begin
               st_next.upd = UPD_READ;
            end
         end
         UPD_READ: begin
            if (stored < target) begin // R19
               st_next.wdata = target;
               st_next.lowest = (target > 64'(ctx_window)) ? target - 64'(ctx_window) :
                  64'h0000_0000_0000_0001; // R21
               st_next.wr = 1'b1;
               st_next.upd = UPD_WRITE;
            end else begin
               st_next.req = 1'b0; // R20
               st_next.upd = UPD_IDLE;
            end
         end
         UPD_WRITE: begin
            st_next.req = 1'b0; // R22
            st_next.upd = UPD_IDLE;
         end
      endcase

      st_next.ph_valid = take;
      if (take) begin
         st_next.ph_write = hwrite;
         st_next.ph_addr = haddr[7:0];
      end
      st_next.rdata = 32'h0000_0000;
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            OFF_CRYPTO_ERROR_STATUS: st_next.rdata = st_reg.status;
            OFF_CRYPTO_ERROR_ENABLE: st_next.rdata = st_reg.enable;
            OFF_PN_WARNING_THRESHOLD: st_next.rdata = st_reg.threshold;
            OFF_DROP_STATUS: st_next.rdata = 32'(st_reg.drop_st);
            OFF_DROP_ENABLE: st_next.rdata = 32'(st_reg.drop_en);
            OFF_PN_TARGET_LOW: st_next.rdata = st_reg.tgt_lo;
            OFF_PN_TARGET_HIGH: st_next.rdata = st_reg.tgt_hi;
            OFF_PN_TARGET_FLOW_SELECT: st_next.rdata = 32'(st_reg.tgt_ctx);
            OFF_PN_UPDATE_CTRL: st_next.rdata = {30'h000_0000, st_reg.xpn, st_reg.req};
            OFF_IN_OVERRUN_COUNT: st_next.rdata = RST_ZERO; // R15
            default: st_next.rdata = RST_ZERO;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.threshold <= RST_PN_WARNING_THRESHOLD;
         st_reg.upd <= UPD_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hrdata = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ctx_addr = st_reg.tgt_ctx;
   assign ctx_wr = st_reg.wr;
   assign ctx_pn_wdata = st_reg.wdata;
   assign ctx_lowest_pn = st_reg.lowest;
   assign ctx_sel_sa = st_reg.stat_sel;
   assign sa_octets = octets_reg[st_reg.stat_sel[CTX_W-1:0]];
   assign sa_out_pkts = pkts_reg[st_reg.stat_sel[CTX_W-1:0]];
   // R1: seven drop sources plus crypto give five ingress, four egress
   assign crypto_irq = |(st_reg.status & st_reg.enable); // R23
   assign drop_irq = |(st_reg.drop_st & st_reg.drop_en); // R1 R23

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      core_fault.input_err |=> st_reg.status[BIT_INPUT_ERR];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("input error not latched"); // R3

   property p_fatal;
      @(posedge hclk) disable iff (!hresetn)
      core_fault.fatal_err |=> st_reg.status[BIT_FATAL_ERR] && st_reg.status[BIT_FATAL_ERR];
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal error not latched"); // R4

   property p_thresh;
      @(posedge hclk) disable iff (!hresetn)
      (egress_pn.valid && egress_pn.pn > st_reg.threshold) |=> st_reg.status[BIT_PN_THRESH];
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold warning missed"); // R7

   property p_w1c;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.ph_valid && st_reg.ph_write && st_reg.ph_addr == OFF_CRYPTO_ERROR_STATUS
       && hwdata[BIT_CTX_ERR] && !core_fault.ctx_err) |=> !st_reg.status[BIT_CTX_ERR];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear"); // R2

   property p_drop_latch;
      @(posedge hclk) disable iff (!hresetn)
      drop_event.in_consist |=> st_reg.drop_st[5] [*2];
   endproperty
   a_drop_latch: assert property (p_drop_latch) else $error("drop not held"); // R12 R23

   property p_irq_gate;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.drop_en == '0 && st_reg.enable == RST_ZERO) |-> !drop_irq && !crypto_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt passed disabled"); // R23

   property p_upd_write;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.upd == UPD_READ && stored < target) |=> ctx_wr && ctx_pn_wdata == $past(target);
   endproperty
   a_upd_write: assert property (p_upd_write) else $error("forward update missed"); // R19

   property p_no_write;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.upd == UPD_READ && stored >= target) |=> !ctx_wr ##1 !ctx_wr;
   endproperty
   a_no_write: assert property (p_no_write) else $error("record written wrongly"); // R20

   property p_selfclear;
      @(posedge hclk) disable iff (!hresetn)
      $rose(st_reg.req) |-> ##[1:3] !st_reg.req;
   endproperty
   a_selfclear: assert property (p_selfclear) else $error("request not cleared"); // R22

   property p_overrun;
      @(posedge hclk) disable iff (!hresetn)
      (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_IN_OVERRUN_COUNT)
      |=> hrdata == RST_ZERO;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun count not zero"); // R15

   property p_out_err;
      @(posedge hclk) disable iff (!hresetn)
      core_fault.output_err |=> st_reg.status[BIT_OUTPUT_ERR];
   endproperty
   a_out_err: assert property (p_out_err) else $error("output error not latched"); // R4

   property p_proc_err;
      @(posedge hclk) disable iff (!hresetn)
      core_fault.proc_err |=> st_reg.status[BIT_PROC_ERR];
   endproperty
   a_proc_err: assert property (p_proc_err) else $error("processing error not latched"); // R5

   property p_ctx_err;
      @(posedge hclk) disable iff (!hresetn)
      core_fault.ctx_err |=> st_reg.status[BIT_CTX_ERR];
   endproperty
   a_ctx_err: assert property (p_ctx_err) else $error("context error not latched"); // R6

   property p_post_drop;
      @(posedge hclk) disable iff (!hresetn)
      drop_event.in_post |=> st_reg.drop_st[4];
   endproperty
   a_post_drop: assert property (p_post_drop) else $error("post drop not latched"); // R13

   property p_mtu_drop;
      @(posedge hclk) disable iff (!hresetn)
      drop_event.out_mtu |=> st_reg.drop_st[0];
   endproperty
   a_mtu_drop: assert property (p_mtu_drop) else $error("mtu drop not latched"); // R14

   property p_pn_quiet;
      @(posedge hclk) disable iff (!hresetn)
      (!st_reg.status[BIT_PN_THRESH] && !(egress_pn.valid && egress_pn.pn > st_reg.threshold))
      |=> !st_reg.status[BIT_PN_THRESH];
   endproperty
   a_pn_quiet: assert property (p_pn_quiet) else $error("threshold warning without cause"); // R7

   property p_wr_once;
      @(posedge hclk) disable iff (!hresetn)
      ctx_wr |=> !ctx_wr;
   endproperty
   a_wr_once: assert property (p_wr_once) else $error("record written twice"); // R22

   property p_lowest;
      @(posedge hclk) disable iff (!hresetn)
      ctx_wr |-> (ctx_lowest_pn <= ctx_pn_wdata) && (ctx_lowest_pn != '0);
   endproperty
   a_lowest: assert property (p_lowest) else $error("lowest pn out of range"); // R21

   property p_octets;
      @(posedge hclk) disable iff (!hresetn)
      (in_octet.valid && in_octet.ctx == ctx_sel_sa[CTX_W-1:0]) |=> ctx_sel_sa != $past(ctx_sel_sa)
      || sa_octets == $past(sa_octets) + 48'($past(in_octet.octets));
   endproperty
   a_octets: assert property (p_octets) else $error("sa octets not added"); // R16

   property p_pkts;
      @(posedge hclk) disable iff (!hresetn)
      (out_pkt.valid && out_pkt.ctx == ctx_sel_sa[CTX_W-1:0]) |=> ctx_sel_sa != $past(ctx_sel_sa)
      || sa_out_pkts == $past(sa_out_pkts) + 40'h00_0000_0001;
   endproperty
   a_pkts: assert property (p_pkts) else $error("sa packets not counted"); // R17

endmodule
`default_nettype wire

// file: verilog/sec_event_pkg.sv
// package for the macsec event and packet-number update block
// assumes a single 200 MHz clock and an ahb-lite register bus
package sec_event_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CRYPTO_ERROR_STATUS = 8'h00;
   localparam logic [7:0] OFF_CRYPTO_ERROR_ENABLE = 8'h04;
   localparam logic [7:0] OFF_PN_WARNING_THRESHOLD = 8'h08;
   localparam logic [7:0] OFF_DROP_STATUS = 8'h0C;
   localparam logic [7:0] OFF_DROP_ENABLE = 8'h10;
   localparam logic [7:0] OFF_PN_TARGET_LOW = 8'h14;
   localparam logic [7:0] OFF_PN_TARGET_HIGH = 8'h18;
   localparam logic [7:0] OFF_PN_TARGET_FLOW_SELECT = 8'h1C;
   localparam logic [7:0] OFF_PN_UPDATE_CTRL = 8'h20;
   localparam logic [7:0] OFF_IN_OVERRUN_COUNT = 8'h24;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_INPUT_ERR = 0;
   localparam int BIT_OUTPUT_ERR = 1;
   localparam int BIT_PROC_ERR = 2;
   localparam int BIT_CTX_ERR = 3;
   localparam int BIT_PN_THRESH = 4;
   localparam int BIT_FATAL_ERR = 14;
   localparam logic [31:0] CRYPTO_STATUS_MASK = 32'h0000_401F;
   // drop status: [6] class, [5] consist, [4] post, [3] mtu (ingress)
   //              [2] class, [1] post, [0] mtu (egress)
   localparam int NUM_DROP = 7;
   localparam int BIT_UPDATE_REQ = 0;
   localparam int BIT_XPN = 1;

   // ---------------------------------------------------------------
   // reset values and sizes
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_PN_WARNING_THRESHOLD = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam int NUM_CTX = 8;
   localparam int CTX_W = 3;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic input_err;
      logic output_err;
      logic proc_err;
      logic ctx_err;
      logic fatal_err;
   } core_fault_t;

   typedef struct packed {
      logic in_class;
      logic in_consist;
      logic in_post;
      logic in_mtu;
      logic out_class;
      logic out_post;
      logic out_mtu;
   } drop_event_t;

   typedef struct packed {
      logic valid;
      logic [CTX_W-1:0] ctx;
      logic [31:0] pn;
   } egress_pn_t;

   typedef struct packed {
      logic valid;
      logic [CTX_W-1:0] ctx;
      logic auth_only;
      logic [15:0] octets;
   } in_octet_t;

   typedef struct packed {
      logic valid;
      logic [CTX_W-1:0] ctx;
      logic auth_only;
   } out_pkt_t;

   typedef enum logic [1:0] {
      UPD_IDLE = 2'b00,
      UPD_READ = 2'b01,
      UPD_WRITE = 2'b11
   } upd_state_t;

endpackage
